// ---- hdl/abc_decoder.v ----
/*
 Atomic bit-clear decoder and executor for byte, halfword and quadword forms.
 Assumes a register file with three read ports and two write ports, and a
 memory port that performs one indivisible read-modify-write per request
 with a valid/ready handshake and a one-cycle response strobe.
*/
// Functional notes
// - Byte form clears operand-byte bits in memory and returns the old byte.
// - Halfword form does the same on sixteen bits.
// - Quad form clears with a register-pair value and returns old 128 bits.
// - Quad form takes its pair from the destination field and bits 20:16.
// - Narrow forms acquire only when A is set and dest is not all ones.
// - Release applies whenever R is set.
// - Quad forms acquire whenever A is set.
// - With A and R clear the access has no ordering.
// - Bits 23 and 22 select one of four ordering variants per width.
// - Narrow forms are undefined without the large atomics feature.
// - Base 31 selects the stack pointer, checked for alignment.
// - Tag checking is marked only when the base is not 31.
// - Narrow results are zero-extended; dest 31 writes no register.
// - Operand is the low 8 or 16 bits of the operand register.
// - Little-endian puts low half in the first register; big swaps.
// - Quad form is undefined if either register field is all ones.
`timescale 1ns/1ps
`include "abc_defines.vh"

module abc_decoder
#(
	parameter LARGE_ATOMICS = 1,
	parameter QUAD_ATOMICS  = 1
)
(
	input  wire         core_clk,
	input  wire         sys_rst,
	input  wire         insn_valid,
	output wire         insn_ready,
	input  wire [31:0]  insn_word,
	input  wire         big_endian,
	input  wire         sp_align_check,
	output wire [4:0]   rf_rd_a_idx,
	output wire [4:0]   rf_rd_b_idx,
	output wire [4:0]   rf_rd_c_idx,
	input  wire [63:0]  rf_rd_a_data,
	input  wire [63:0]  rf_rd_b_data,
	input  wire [63:0]  rf_rd_c_data,
	input  wire [63:0]  sp_value,
	output wire         mem_req_valid,
	input  wire         mem_req_ready,
	output wire [63:0]  mem_addr,
	output wire [1:0]   mem_width,
	output wire [127:0] mem_clear_mask,
	output wire         mem_acquire,
	output wire         mem_release,
	output wire         mem_tag_check,
	input  wire         mem_rsp_valid,
	input  wire [127:0] mem_rsp_data,
	output wire         wb0_en,
	output wire [4:0]   wb0_idx,
	output wire [63:0]  wb0_data,
	output wire         wb1_en,
	output wire [4:0]   wb1_idx,
	output wire [63:0]  wb1_data,
	output wire         undef_insn,
	output wire         sp_align_fault,
	output wire         done
);

	localparam ST_IDLE = 3'h1;
	localparam ST_MEM  = 3'h2;
	localparam ST_WAIT = 3'h4;

	// Sequencer
	reg  [2:0]   state_reg;
	reg  [2:0]   state_next;

	// Request fields, held towards memory until accepted
	reg          req_valid_reg;
	reg          req_valid_next;
	reg  [63:0]  addr_reg;
	reg  [1:0]   width_reg;
	reg  [1:0]   width_next;
	reg  [127:0] mask_reg;
	reg  [127:0] mask_next;
	reg          acquire_reg;
	reg          acquire_next;
	reg          release_reg;
	reg          tag_check_reg;

	// Destinations kept for the response
	reg  [4:0]   dest_reg;
	reg  [4:0]   dest2_reg;

	// Write-back and status
	reg          wb0_en_reg;
	reg          wb0_en_next;
	reg  [4:0]   wb0_idx_reg;
	reg  [63:0]  wb0_data_reg;
	reg  [63:0]  wb0_data_next;
	reg          wb1_en_reg;
	reg  [4:0]   wb1_idx_reg;
	reg  [63:0]  wb1_data_reg;
	reg  [63:0]  wb1_data_next;
	reg          undef_reg;
	reg          sp_fault_reg;
	reg          done_reg;

	wire [4:0] dest_reg_field        = insn_word[`ABC_DEST_HI:`ABC_DEST_LO];
	wire [4:0] base_reg_field        = insn_word[`ABC_BASE_HI:`ABC_BASE_LO];
	// Same bits serve as operand field (narrow) and second dest (quad)
	wire [4:0] operand_reg_field     = insn_word[`ABC_OPS_HI:`ABC_OPS_LO];
	wire [4:0] second_dest_reg_field = insn_word[`ABC_OPS_HI:`ABC_OPS_LO];
	wire [1:0] size_f = insn_word[`ABC_SIZE_HI:`ABC_SIZE_LO];
	wire       acq_f  = insn_word[`ABC_ACQ_BIT];
	wire       rel_f  = insn_word[`ABC_REL_BIT];

	wire narrow_hit = (insn_word & `ABC_NARROW_MASK) == `ABC_NARROW_MATCH;
	wire is_byte = narrow_hit && size_f == `ABC_SIZE_BYTE;
	wire is_half = narrow_hit && size_f == `ABC_SIZE_HALF;
	wire is_quad = (insn_word & `ABC_QUAD_MASK) == `ABC_QUAD_MATCH;
	wire is_narrow = is_byte || is_half;

	// narrow forms need the large atomics feature
	wire narrow_undef = is_narrow && (LARGE_ATOMICS == 0);
	// quad register fields must not be all ones
	wire quad_undef = is_quad && (QUAD_ATOMICS == 0 ||
		dest_reg_field == `ABC_REG_ALL1 ||
		second_dest_reg_field == `ABC_REG_ALL1);
	wire any_undef = !is_narrow && !is_quad || narrow_undef || quad_undef;

	// base 31 is the stack pointer
	wire base_is_sp = base_reg_field == `ABC_REG_ALL1;
	wire [63:0] base_addr = base_is_sp ? sp_value : rf_rd_a_data;
	wire sp_misaligned = base_is_sp && sp_align_check &&
		(sp_value[3:0] != 4'h0);

	// pair comes from dest field and bits 20:16
	assign rf_rd_a_idx = base_reg_field;
	assign rf_rd_b_idx = is_quad ? dest_reg_field : operand_reg_field;
	assign rf_rd_c_idx = second_dest_reg_field;

	assign insn_ready = state_reg == ST_IDLE;
	wire take = insn_valid && insn_ready;
	// Only a legal instruction with no stack pointer alignment fault reaches memory
	wire start  = take && !any_undef && !sp_misaligned;
	wire accept = state_reg == ST_MEM && mem_req_ready;
	wire finish = state_reg == ST_WAIT && mem_rsp_valid;
	// Width is frozen at issue, so it tells the response apart
	wire quad_rsp = width_reg == `ABC_W_QUAD;

	always @*
	begin
		mask_next = 128'h0;
		// low 8 or 16 operand bits
		if (is_byte)
			mask_next[7:0] = rf_rd_b_data[7:0];
		else if (is_half)
			mask_next[15:0] = rf_rd_b_data[15:0];
		else if (big_endian)
			mask_next = {rf_rd_b_data, rf_rd_c_data};
		else
			mask_next = {rf_rd_c_data, rf_rd_b_data};
	end

	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (take && !any_undef && !sp_misaligned)
					state_next = ST_MEM;
			ST_MEM:
				if (mem_req_ready)
					state_next = ST_WAIT;
			ST_WAIT:
				if (mem_rsp_valid)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	// access width from the decoded form
	always @*
	begin
		if (is_byte)
			width_next = `ABC_W_BYTE;
		else if (is_half)
			width_next = `ABC_W_HALF;
		else
			width_next = `ABC_W_QUAD;
	end

	always @*
	begin
		acquire_next = 1'h0;
		if (acq_f)
			acquire_next = is_quad || dest_reg_field != `ABC_REG_ALL1;
	end

	// Request stands until memory takes it
	always @*
	begin
		req_valid_next = req_valid_reg;
		if (accept)
			req_valid_next = 1'h0;
		if (start)
			req_valid_next = 1'h1;
	end

	// Old data is kept between responses; only the enables pulse
	always @*
	begin
		wb0_en_next   = 1'h0;
		wb0_data_next = wb0_data_reg;
		wb1_data_next = wb1_data_reg;
		if (finish && quad_rsp)
		begin
			// endian selects which half goes where
			wb0_en_next = 1'h1;
			if (big_endian)
			begin
				wb0_data_next = mem_rsp_data[127:64];
				wb1_data_next = mem_rsp_data[63:0];
			end
			else
			begin
				wb0_data_next = mem_rsp_data[63:0];
				wb1_data_next = mem_rsp_data[127:64];
			end
		end
		else if (finish)
		begin
			// zero-extend; no write to register 31
			wb0_en_next = dest_reg != `ABC_REG_ALL1;
			if (width_reg == `ABC_W_BYTE)
				wb0_data_next = {56'h0, mem_rsp_data[7:0]};
			else
				wb0_data_next = {48'h0, mem_rsp_data[15:0]};
		end
	end

	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_reg     <= ST_IDLE;
			req_valid_reg <= 1'h0;
			addr_reg      <= 64'h0;
			width_reg     <= `ABC_W_BYTE;
			mask_reg      <= 128'h0;
			acquire_reg   <= 1'h0;
			release_reg   <= 1'h0;
			tag_check_reg <= 1'h0;
			dest_reg      <= 5'h0;
			dest2_reg     <= 5'h0;
			wb0_en_reg    <= 1'h0;
			wb0_idx_reg   <= 5'h0;
			wb0_data_reg  <= 64'h0;
			wb1_en_reg    <= 1'h0;
			wb1_idx_reg   <= 5'h0;
			wb1_data_reg  <= 64'h0;
			undef_reg     <= 1'h0;
			sp_fault_reg  <= 1'h0;
			done_reg      <= 1'h0;
		end
		else
		begin
			state_reg     <= state_next;
			req_valid_reg <= req_valid_next;
			wb0_en_reg    <= wb0_en_next;
			wb0_data_reg  <= wb0_data_next;
			wb1_en_reg    <= finish && quad_rsp;
			wb1_data_reg  <= wb1_data_next;
			undef_reg     <= take && any_undef;
			sp_fault_reg  <= take && !any_undef && sp_misaligned;
			done_reg      <= finish;
			if (start)
			begin
				addr_reg      <= base_addr;
				width_reg     <= width_next;
				// Memory applies old & ~mask
				mask_reg      <= mask_next;
				acquire_reg   <= acquire_next;
				release_reg   <= rel_f;
				tag_check_reg <= !base_is_sp;
				dest_reg      <= dest_reg_field;
				dest2_reg     <= second_dest_reg_field;
			end
			if (finish)
				wb0_idx_reg <= dest_reg;
			if (finish && quad_rsp)
				wb1_idx_reg <= dest2_reg;
		end
	end

	assign mem_req_valid  = req_valid_reg;
	assign mem_addr       = addr_reg;
	assign mem_width      = width_reg;
	assign mem_clear_mask = mask_reg;
	assign mem_acquire    = acquire_reg;
	assign mem_release    = release_reg;
	assign mem_tag_check  = tag_check_reg;
	assign wb0_en         = wb0_en_reg;
	assign wb0_idx        = wb0_idx_reg;
	assign wb0_data       = wb0_data_reg;
	assign wb1_en         = wb1_en_reg;
	assign wb1_idx        = wb1_idx_reg;
	assign wb1_data       = wb1_data_reg;
	assign undef_insn     = undef_reg;
	assign sp_align_fault = sp_fault_reg;
	assign done           = done_reg;

endmodule

// ---- hdl/abc_defines.vh ----
/*
 Constants for the atomic bit-clear decoder: instruction fields, opcode
 patterns and access width codes. Definitions only.
*/
`ifndef ABC_DEFINES_VH
`define ABC_DEFINES_VH
`define ABC_SIZE_HI      31
`define ABC_SIZE_LO      30
`define ABC_ACQ_BIT      23
`define ABC_REL_BIT      22
`define ABC_OPS_HI       20
`define ABC_OPS_LO       16
`define ABC_BASE_HI      9
`define ABC_BASE_LO      5
`define ABC_DEST_HI      4
`define ABC_DEST_LO      0
`define ABC_REG_ALL1     5'h1f
`define ABC_SIZE_BYTE    2'h0
`define ABC_SIZE_HALF    2'h1
`define ABC_SIZE_QUAD    2'h0
// Fixed bits outside A, R, register fields, and outside size for narrow forms only (mask / match)
`define ABC_NARROW_MASK  32'h3f20_fc00
`define ABC_NARROW_MATCH 32'h3820_1000
`define ABC_QUAD_MASK    32'hff20_fc00
`define ABC_QUAD_MATCH   32'h1920_1000
`define ABC_W_BYTE       2'h0
`define ABC_W_HALF       2'h1
`define ABC_W_QUAD       2'h2
`endif

// ---- test/abc_chk_asserts.sv ----
/*
 Port checker for abc_decoder.
 Assumes the decoder ports only; bound at the foot of this file.
*/
`timescale 1ns/1ps
module abc_chk(
	input wire core_clk, sys_rst, insn_valid, insn_ready, big_endian,
	input wire [31:0] insn_word,
	input wire [63:0] rf_rd_a_data, rf_rd_b_data, rf_rd_c_data, sp_value,
	input wire mem_req_valid, mem_acquire, mem_release, mem_tag_check,
	input wire [63:0] mem_addr,
	input wire [1:0] mem_width,
	input wire [127:0] mem_clear_mask,
	input wire mem_rsp_valid, undef_insn, done
);
	reg [31:0] w_reg;
	reg [63:0] a_reg, b_reg, c_reg, s_reg;
	reg e_reg;
	// Inputs as seen at the edge that takes the instruction
	always @(posedge core_clk)
	begin
		{w_reg, a_reg, b_reg, c_reg, s_reg, e_reg} <= {insn_word,
			rf_rd_a_data, rf_rd_b_data, rf_rd_c_data, sp_value, big_endian};
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_iss; $rose(mem_req_valid); endsequence
	sequence s_fin; mem_rsp_valid ##1 done; endsequence
	property p_rel; s_iss |-> mem_release == w_reg[22]; endproperty
	property p_acq; s_iss |-> mem_acquire ==
		(w_reg[23] && (w_reg[24] || w_reg[4:0] != 5'h1f)); endproperty
	property p_tag; s_iss |-> mem_tag_check == (w_reg[9:5] != 5'h1f);
	endproperty
	property p_adr; s_iss |-> mem_addr == (&w_reg[9:5] ? s_reg : a_reg);
	endproperty
	property p_wid; s_iss |->
		mem_width == (w_reg[24] ? 2'h2 : {1'b0, w_reg[30]}); endproperty
	property p_mkn; s_iss ##0 !w_reg[24] |-> mem_clear_mask == (w_reg[30] ?
		{112'h0, b_reg[15:0]} : {120'h0, b_reg[7:0]}); endproperty
	property p_mkq; s_iss ##0 w_reg[24] |-> mem_clear_mask ==
		(e_reg ? {b_reg, c_reg} : {c_reg, b_reg}); endproperty
	property p_fin; mem_rsp_valid |-> s_fin; endproperty
	property p_und; insn_valid && insn_ready && insn_word[31:24] == 8'h19
		&& (&insn_word[4:0] || &insn_word[20:16])
		|=> undef_insn && !mem_req_valid; endproperty
	a_rel: assert property (p_rel) else $error("release flag");
	a_acq: assert property (p_acq) else $error("acquire flag");
	a_tag: assert property (p_tag) else $error("tag check");
	a_adr: assert property (p_adr) else $error("address");
	a_wid: assert property (p_wid) else $error("width");
	a_mkn: assert property (p_mkn) else $error("narrow mask");
	a_mkq: assert property (p_mkq) else $error("quad mask");
	a_fin: assert property (p_fin) else $error("no done");
	a_und: assert property (p_und) else $error("no undef");
endmodule
bind abc_decoder abc_chk u_abc_chk(.*);

// ---- test/abc_mem.sv ----
/*
 Memory side model: one 128-bit cell, ready lag+1 cycles after the request.
 Assumes the bench loads the cell while the port is idle.
*/
`timescale 1ns/1ps
module abc_mem(
	input wire core_clk, sys_rst, mem_req_valid,
	input wire [1:0] mem_width, lag,
	input wire [127:0] mem_clear_mask,
	output reg mem_req_ready, mem_rsp_valid,
	output reg [127:0] mem_rsp_data
);
	reg [127:0] cell_reg;
	reg [1:0] cnt_reg;
	wire [127:0] wmask = mem_width[1] ? ~128'h0 :
		(mem_width[0] ? 128'hffff : 128'hff);
	always @(posedge core_clk)
	begin
		mem_req_ready <= 1'b0;
		mem_rsp_valid <= 1'b0;
		// Stale data inverts so nothing reads it by luck
		mem_rsp_data <= ~mem_rsp_data;
		if (sys_rst)
			{cnt_reg, mem_rsp_data} <= 130'h0;
		else if (mem_req_ready)
		begin
			// old value out, cleared value kept
			{mem_rsp_valid, mem_rsp_data, cnt_reg} <= {1'b1, cell_reg, 2'h0};
			cell_reg <= cell_reg & ~(mem_clear_mask & wmask);
		end
		else if (mem_req_valid)
		begin
			mem_req_ready <= cnt_reg == lag;
			cnt_reg <= cnt_reg + 2'h1;
		end
	end
endmodule

// ---- test/atomic_bit_clear_decode_bench.sv ----
/*
 Bench for abc_decoder with the abc_mem model.
 Assumes a same-cycle register file modelled here.
*/
`timescale 1ns/1ps
module atomic_bit_clear_decode_bench;
	localparam [127:0] M = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
	reg core_clk = 0, sys_rst = 1, insn_valid = 0, big_endian = 0;
	reg sp_align_check = 0;
	reg [31:0] insn_word = 0;
	reg [63:0] sp_value = 0;
	reg [1:0] lag = 0;
	wire insn_ready, mem_req_valid, mem_req_ready, mem_acquire, mem_release;
	wire mem_tag_check, mem_rsp_valid, wb0_en, wb1_en, undef_insn;
	wire sp_align_fault, done;
	wire [4:0] rf_rd_a_idx, rf_rd_b_idx, rf_rd_c_idx, wb0_idx, wb1_idx;
	wire [63:0] rf_rd_a_data, rf_rd_b_data, rf_rd_c_data, mem_addr;
	wire [63:0] wb0_data, wb1_data;
	wire [1:0] mem_width;
	wire [127:0] mem_clear_mask, mem_rsp_data;
	integer failures = 0, tests_run = 0, cyc = 0, n, k;
	function [63:0] rv(input [4:0] i);
		rv = {8{i, 3'h5}};
	endfunction
	function [31:0] enc(input q, h, a, r, input [4:0] s, b, t);
		enc = (q ? 32'h1920_1000 : 32'h3820_1000) |
			{1'b0, h, 6'h0, a, r, 1'b0, s, 6'h0, b, t};
	endfunction
	assign rf_rd_a_data = rv(rf_rd_a_idx);
	assign rf_rd_b_data = rv(rf_rd_b_idx);
	assign rf_rd_c_data = rv(rf_rd_c_idx);
	abc_decoder u_abc_decoder(.*);
	abc_mem u_abc_mem(.*);
	always #10 core_clk = ~core_clk;
	task chk(input string nm, input [127:0] s, e);
	begin
		tests_run++;
		if (s !== e)
		begin
			failures++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	end
	endtask
	task results;
	begin
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task op(input [31:0] w);
	begin
		u_abc_mem.cell_reg = M;
		for (n = 0; insn_ready !== 1'b1 && n < 9; n++)
			@(posedge core_clk) #1;
		{insn_word, insn_valid} = {w, 1'b1};
		@(posedge core_clk) #1 insn_valid = 0;
		for (n = 0; (done | undef_insn | sp_align_fault) !== 1'b1 && n < 40;
			n++)
			@(posedge core_clk) #1;
		chk("finish", n < 40, 1);
	end
	endtask
	task t_byte;
		for (k = 0; k < 4; k++)
		begin
			lag = k;
			op(enc(0, 0, k[1], k[0], 2, 7, 3));
			chk("b data", {wb0_en, wb0_idx, wb0_data}, {6'h23, 56'h0, M[7:0]});
			chk("b mem", u_abc_mem.cell_reg, M & ~(rv(2) & 128'hff));
		end
	endtask
	task t_half;
	begin
		{sp_align_check, sp_value, lag} = {1'b1, 64'h100, 2'h3};
		op(enc(0, 1, 1, 1, 6, 31, 31));
		chk("h wb", wb0_en, 0);
		chk("h mem", u_abc_mem.cell_reg, M & ~(rv(6) & 128'hffff));
		op(enc(0, 1, 1, 0, 6, 31, 4));
		chk("h data", {wb0_en, wb0_data}, {1'b1, 48'h0, M[15:0]});
	end
	endtask
	task t_quad;
		for (k = 0; k < 2; k++)
		begin
			big_endian = k[0];
			op(enc(1, 0, k[0], 1, 9, 4, 2));
			chk("q idx", {wb1_en, wb1_idx, wb0_idx}, {1'b1, 5'h09, 5'h02});
			chk("q data", {wb1_data, wb0_data}, k ? {M[63:0], M[127:64]} : M);
			chk("q mem", u_abc_mem.cell_reg,
				M & ~(k ? {rv(2), rv(9)} : {rv(9), rv(2)}));
		end
	endtask
	task t_fault;
	begin
		sp_value = 64'h8;
		op(enc(0, 0, 0, 0, 5, 31, 3));
		chk("sp fault", {sp_align_fault, u_abc_mem.cell_reg}, {1'b1, M});
		op(enc(1, 0, 0, 0, 9, 4, 31));
		chk("q rt", undef_insn, 1);
		op(enc(1, 0, 0, 0, 31, 4, 2));
		chk("q rt2", undef_insn, 1);
		op(enc(0, 0, 0, 0, 5, 4, 3) | 32'h8000_0000);
		chk("size 10", undef_insn, 1);
	end
	endtask
	initial
	begin
		repeat (8) @(posedge core_clk);
		#1 sys_rst = 0;
		t_byte;
		t_half;
		t_quad;
		t_fault;
		results;
	end
	// Cuts a hang short
	always @(posedge core_clk)
		if (++cyc == 5000)
		begin
			failures++;
			results;
		end
endmodule
